// ### design/flash_prog_regs.svh
// Constants of the parallel production-programming command layer.
// Assumes inclusion by its bare name from the package and the design module.
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH

// ----------------------------------------------------------------------
// Mode field codes of a handshake
// ----------------------------------------------------------------------
`define FP_MODE_CMD 4'h0
`define FP_MODE_ADDRESS_BYTE_0 4'h1
`define FP_MODE_ADDRESS_BYTE_3 4'h4
`define FP_MODE_DATA 4'h5

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define FP_CMD_READ_FLASH 16'h0011
`define FP_CMD_WRITE_PAGE 16'h0012
`define FP_CMD_WRITE_PAGE_LOCK 16'h0022
`define FP_CMD_ERASE_WRITE_PAGE 16'h0032
`define FP_CMD_ERASE_WRITE_LOCK 16'h0042
`define FP_CMD_ERASE_ALL 16'h0013
`define FP_CMD_SET_LOCK 16'h0014
`define FP_CMD_CLEAR_LOCK 16'h0024
`define FP_CMD_READ_LOCK 16'h0015
`define FP_CMD_SET_OPTION 16'h0034
`define FP_CMD_CLEAR_OPTION 16'h0044
`define FP_CMD_READ_OPTION 16'h0025
`define FP_CMD_SET_SECURITY 16'h0054
`define FP_CMD_READ_SECURITY 16'h0035
`define FP_CMD_READ_VERSION 16'h001e
`define FP_CMD_MEM_READ 16'h0016
`define FP_CMD_MEM_WRITE 16'h0026

// ----------------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------------
`define FP_CMD_RESET 16'h0000
`define FP_ADDR_RESET 32'h0000_0000
`define FP_VERSION_DEFAULT 16'h0001

`endif

// ### design/flash_prog_pkg.sv
// Types shared by the programming command layer.
// Assumes the constants header sits beside it on the include path.
`default_nettype none

package flash_prog_pkg;
  `include "flash_prog_regs.svh"

  // Operations requested from the flash controller.
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ERASE_PAGE = 2'b01,
    OP_PROGRAM_PAGE = 2'b10,
    OP_ERASE_ALL = 2'b11
  } ctl_op_e;

  // Sequencer states.
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_EXEC = 4'b0001,
    S_MEM = 4'b0010,
    S_FL_ERASE = 4'b0011,
    S_FL_PROG = 4'b0100,
    S_ERASE_ALL = 4'b0101,
    S_OE_WAIT = 4'b0110,
    S_DRIVE = 4'b0111,
    S_WAIT_HIGH = 4'b1000,
    S_PIN_ERASE = 4'b1001
  } seq_state_e;
endpackage

`default_nettype wire

// ### design/flash_prog_command_seq.sv
// Command sequencer of the parallel production-programming port.
// Assumes pins already synchronous to core_clk, a memory bus slave that
// answers memReq with a one-cycle memAck, and a flash controller that
// answers ctlReq with a one-cycle ctlAck and reads the load buffer itself.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`default_nettype none

`include "flash_prog_regs.svh"

// Summary of operation
// - Mode 0 loads command, 1 to 4 address bytes low first, 5 data, others nothing.
// - In command mode the strobed word becomes the new command.
// - Handshake starts only while ready; ready drops on latch, returns when done.
// - Read handshake drives the bus after output enable falls, releases when it rises.
// - A new command completes the previous one, flushing pending writes.
// - Flash read: command, four address bytes, then chained auto-incrementing reads.
// - Four new address bytes may be loaded anytime without repeating the command.
// - Write data collects in a one-page load buffer, address advancing per word.
// - Touching another page programs the pending load buffer first.
// - Accepting a new command programs the pending load buffer.
// - Four write-page commands use the read sequence with write data handshakes.
// - Write-then-lock sets the region lock bit after programming finishes.
// - Erase-then-write erases the page before programming the buffer.
// - Erase-write-lock erases, programs, then sets the region lock bit.
// - Erase-all aborts, erasing nothing, while any lock region is locked.
// - Set and clear lock take a mask, bit 0 first; erase-all clears locks.
// - Read lock mask returns bit n set when lock bit n is set.
// - Set and clear option take a pattern; erase-all clears option bits.
// - Read option bits returns bit n set when option bit n is set.
// - Once security is set no further command executes.
// - Security clears only by the erase input after the flash is erased.
// - Memory read walks any map address with auto-increment.
// - Memory write writes any map address, advancing per data handshake.
// - Get version returns the interface version in one data read.
module flash_prog_command_seq #(
  parameter int DATA_W = 16,
  parameter int ADDR_STEP = 2,
  parameter int WORD_SHIFT = 1,
  parameter int PAGE_SHIFT = 8,
  parameter int REGION_SHIFT = 6,
  parameter int LOCK_N = 16,
  parameter int OPT_N = 2,
  parameter logic [15:0] VERSION = `FP_VERSION_DEFAULT
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic command_strobe_n,
  input wire logic output_enable_n,
  input wire logic [3:0] mode,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  output logic ready,
  output logic data_drive_n,
  input wire logic eraseEvent,
  output logic memReq,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [DATA_W-1:0] memWdata,
  input wire logic [DATA_W-1:0] memRdata,
  input wire logic memAck,
  output logic ctlReq,
  output flash_prog_pkg::ctl_op_e ctlOp,
  output logic [31-PAGE_SHIFT:0] ctlPage,
  input wire logic ctlAck,
  input wire logic [PAGE_SHIFT-WORD_SHIFT-1:0] ctlBufIdx,
  output logic [DATA_W-1:0] ctlBufWord,
  output logic ctlBufValid,
  output logic [LOCK_N-1:0] lockBits,
  output logic [OPT_N-1:0] optionBits,
  output logic securityActive
);
  import flash_prog_pkg::*;

  localparam int PAGE_WORDS = 2 ** (PAGE_SHIFT - WORD_SHIFT);
  localparam int WIDX_W = PAGE_SHIFT - WORD_SHIFT;
  localparam int PAGE_W = 32 - PAGE_SHIFT;
  localparam int LOCK_IDX_W = (LOCK_N > 1) ? $clog2(LOCK_N) : 1;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  seq_state_e state, next_state;
  logic [3:0] latchMode, next_latchMode;
  logic [15:0] latchData, next_latchData;
  logic [15:0] cmd, next_cmd;
  logic [31:0] curAddr, next_curAddr;
  logic [PAGE_W-1:0] bufPage, next_bufPage;
  logic dirty, next_dirty;
  logic [PAGE_WORDS-1:0] bufValid, next_bufValid;
  logic [LOCK_N-1:0] next_lockBits;
  logic [OPT_N-1:0] next_optionBits;
  logic next_securityActive;
  logic [DATA_W-1:0] readValue, next_readValue;
  logic eraseReq, next_eraseReq;
  logic bufWrEn;
  logic [DATA_W-1:0] loadBuf [PAGE_WORDS];

  logic writeFamily;
  logic eraseKind;
  logic lockKind;
  logic [PAGE_W-1:0] curPage;
  logic [WIDX_W-1:0] curWordIdx;
  logic [LOCK_IDX_W-1:0] regionIdx;
  logic [1:0] byteSel;

  // Command flavour decode; the buffer keeps the flavour of the command
  // that filled it because the command only changes after a flush.
  assign writeFamily = (cmd == `FP_CMD_WRITE_PAGE) || (cmd == `FP_CMD_WRITE_PAGE_LOCK)
                    || (cmd == `FP_CMD_ERASE_WRITE_PAGE) || (cmd == `FP_CMD_ERASE_WRITE_LOCK);
  assign eraseKind = (cmd == `FP_CMD_ERASE_WRITE_PAGE) || (cmd == `FP_CMD_ERASE_WRITE_LOCK);
  assign lockKind = (cmd == `FP_CMD_WRITE_PAGE_LOCK) || (cmd == `FP_CMD_ERASE_WRITE_LOCK);
  assign curPage = curAddr[31:PAGE_SHIFT];
  assign curWordIdx = curAddr[PAGE_SHIFT-1:WORD_SHIFT];
  assign regionIdx = bufPage[REGION_SHIFT +: LOCK_IDX_W];
  assign byteSel = 2'(latchMode - `FP_MODE_ADDRESS_BYTE_0);

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Ready is only shown in idle so a strobe is never taken mid-operation.
  assign ready = (state == S_IDLE);
  assign dataOe = (state == S_DRIVE);
  assign data_drive_n = (state != S_DRIVE);
  assign dataOut = readValue;
  assign memReq = (state == S_MEM);
  assign memWrite = (cmd == `FP_CMD_MEM_WRITE);
  assign memAddr = curAddr;
  assign memWdata = latchData[DATA_W-1:0];
  assign ctlReq = (state == S_FL_ERASE) || (state == S_FL_PROG)
               || (state == S_ERASE_ALL) || (state == S_PIN_ERASE);
  assign ctlPage = bufPage;

  // Controller operation follows the state directly.
  always_comb
  begin
    unique case (state)
      S_FL_ERASE: ctlOp = OP_ERASE_PAGE;
      S_FL_PROG: ctlOp = OP_PROGRAM_PAGE;
      S_ERASE_ALL, S_PIN_ERASE: ctlOp = OP_ERASE_ALL;
      default: ctlOp = OP_NONE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer next-state logic
  // ----------------------------------------------------------------------
  // Flushes return to S_EXEC, which re-runs the latched handshake against a
  // clean buffer; that keeps one path for both the page-change and the
  // new-command flush.
  always_comb
  begin
    next_state = state;
    next_latchMode = latchMode;
    next_latchData = latchData;
    next_cmd = cmd;
    next_curAddr = curAddr;
    next_bufPage = bufPage;
    next_dirty = dirty;
    next_bufValid = bufValid;
    next_lockBits = lockBits;
    next_optionBits = optionBits;
    next_securityActive = securityActive;
    next_readValue = readValue;
    next_eraseReq = eraseReq | eraseEvent;
    bufWrEn = 1'b0;
    unique case (state)
      S_IDLE:
      begin
        if (eraseReq)
        begin
          next_state = S_PIN_ERASE;
        end
        else if (!command_strobe_n)
        begin
          next_latchMode = mode;
          next_latchData = 16'(dataIn);
          next_state = S_EXEC;
        end
      end
      S_EXEC:
      begin
        next_state = S_WAIT_HIGH;
        if (securityActive)
        begin
          next_state = S_WAIT_HIGH;
        end
        else if (latchMode == `FP_MODE_CMD)
        begin
          if (dirty)
          begin
            next_state = eraseKind ? S_FL_ERASE : S_FL_PROG;
          end
          else
          begin
            next_cmd = latchData;
          end
        end
        else if (latchMode >= `FP_MODE_ADDRESS_BYTE_0 && latchMode <= `FP_MODE_ADDRESS_BYTE_3)
        begin
          next_curAddr[8*byteSel +: 8] = latchData[7:0];
        end
        else if (latchMode == `FP_MODE_DATA)
        begin
          if (writeFamily)
          begin
            if (dirty && curPage != bufPage)
            begin
              next_state = eraseKind ? S_FL_ERASE : S_FL_PROG;
            end
            else
            begin
              bufWrEn = 1'b1;
              next_bufValid[curWordIdx] = 1'b1;
              next_bufPage = curPage;
              next_dirty = 1'b1;
              next_curAddr = curAddr + 32'(ADDR_STEP);
            end
          end
          else
          begin
            unique case (cmd)
              `FP_CMD_READ_FLASH, `FP_CMD_MEM_READ, `FP_CMD_MEM_WRITE:
              begin
                next_state = S_MEM;
              end
              `FP_CMD_ERASE_ALL:
              begin
                if (lockBits == '0)
                begin
                  next_state = S_ERASE_ALL;
                end
              end
              `FP_CMD_SET_LOCK:
              begin
                next_lockBits = lockBits | latchData[LOCK_N-1:0];
              end
              `FP_CMD_CLEAR_LOCK:
              begin
                next_lockBits = lockBits & ~latchData[LOCK_N-1:0];
              end
              `FP_CMD_SET_OPTION:
              begin
                next_optionBits = optionBits | latchData[OPT_N-1:0];
              end
              `FP_CMD_CLEAR_OPTION:
              begin
                next_optionBits = optionBits & ~latchData[OPT_N-1:0];
              end
              `FP_CMD_SET_SECURITY:
              begin
                next_securityActive = 1'b1;
              end
              `FP_CMD_READ_LOCK:
              begin
                next_readValue = DATA_W'(lockBits);
                next_state = S_OE_WAIT;
              end
              `FP_CMD_READ_OPTION:
              begin
                next_readValue = DATA_W'(optionBits);
                next_state = S_OE_WAIT;
              end
              `FP_CMD_READ_SECURITY:
              begin
                next_readValue = DATA_W'(securityActive);
                next_state = S_OE_WAIT;
              end
              `FP_CMD_READ_VERSION:
              begin
                next_readValue = DATA_W'(VERSION);
                next_state = S_OE_WAIT;
              end
              default:
              begin
                next_state = S_WAIT_HIGH;
              end
            endcase
          end
        end
      end
      S_MEM:
      begin
        if (memAck)
        begin
          next_curAddr = curAddr + 32'(ADDR_STEP);
          if (memWrite)
          begin
            next_state = S_WAIT_HIGH;
          end
          else
          begin
            next_readValue = memRdata;
            next_state = S_OE_WAIT;
          end
        end
      end
      S_FL_ERASE:
      begin
        if (ctlAck)
        begin
          next_state = S_FL_PROG;
        end
      end
      S_FL_PROG:
      begin
        if (ctlAck)
        begin
          if (lockKind)
          begin
            next_lockBits[regionIdx] = 1'b1;
          end
          next_dirty = 1'b0;
          next_bufValid = '0;
          next_state = S_EXEC;
        end
      end
      S_ERASE_ALL:
      begin
        if (ctlAck)
        begin
          next_lockBits = '0;
          next_optionBits = '0;
          next_state = S_WAIT_HIGH;
        end
      end
      S_OE_WAIT:
      begin
        if (!output_enable_n)
        begin
          next_state = S_DRIVE;
        end
      end
      S_DRIVE:
      begin
        if (output_enable_n)
        begin
          next_state = S_WAIT_HIGH;
        end
      end
      S_WAIT_HIGH:
      begin
        if (command_strobe_n)
        begin
          next_state = S_IDLE;
        end
      end
      S_PIN_ERASE:
      begin
        if (ctlAck)
        begin
          next_securityActive = 1'b0;
          next_lockBits = '0;
          next_optionBits = '0;
          next_dirty = 1'b0;
          next_bufValid = '0;
          next_eraseReq = eraseEvent;
          next_state = S_IDLE;
        end
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= S_IDLE;
      latchMode <= `FP_MODE_CMD;
      latchData <= `FP_CMD_RESET;
      cmd <= `FP_CMD_RESET;
      curAddr <= `FP_ADDR_RESET;
      bufPage <= '0;
      dirty <= 1'b0;
      bufValid <= '0;
      lockBits <= '0;
      optionBits <= '0;
      securityActive <= 1'b0;
      readValue <= '0;
      eraseReq <= 1'b0;
    end
    else
    begin
      state <= next_state;
      latchMode <= next_latchMode;
      latchData <= next_latchData;
      cmd <= next_cmd;
      curAddr <= next_curAddr;
      bufPage <= next_bufPage;
      dirty <= next_dirty;
      bufValid <= next_bufValid;
      lockBits <= next_lockBits;
      optionBits <= next_optionBits;
      securityActive <= next_securityActive;
      readValue <= next_readValue;
      eraseReq <= next_eraseReq;
    end
  end

  // ----------------------------------------------------------------------
  // Load buffer
  // ----------------------------------------------------------------------
  // The array is not reset; the valid mask tells the controller which words
  // were really loaded, so untouched words keep their flash content.
  always_ff @(posedge core_clk)
  begin
    if (bufWrEn)
    begin
      loadBuf[curWordIdx] <= latchData[DATA_W-1:0];
    end
  end

  // Controller read port, one cycle behind ctlBufIdx.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctlBufWord <= '0;
      ctlBufValid <= 1'b0;
    end
    else
    begin
      ctlBufWord <= loadBuf[ctlBufIdx];
      ctlBufValid <= bufValid[ctlBufIdx];
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  strobe_drops_ready_a: assert property (
    ready && !command_strobe_n && !eraseReq |=> !ready && latchMode == $past(mode))
    else $error("ready did not drop after a taken strobe");

  drive_needs_oe_a: assert property (
    !data_drive_n |-> $past(!output_enable_n) && dataOe)
    else $error("bus driven without output enable");

  release_on_oe_a: assert property (
    !data_drive_n && output_enable_n |=> data_drive_n && !dataOe)
    else $error("bus not released after output enable rose");

  flush_on_cmd_a: assert property (
    state == S_EXEC && latchMode == `FP_MODE_CMD && dirty && !securityActive
    |=> ctlReq && cmd == $past(cmd))
    else $error("new command accepted without flushing buffer");

  addr_advance_a: assert property (
    state == S_MEM && memAck |=> curAddr == $past(curAddr) + 32'(ADDR_STEP))
    else $error("address did not advance after memory access");

  erase_before_prog_a: assert property (
    $rose(state == S_FL_PROG) && eraseKind |-> $past(state) == S_FL_ERASE)
    else $error("page programmed without prior erase");

  lock_after_prog_a: assert property (
    state == S_FL_PROG && ctlAck && lockKind |=> lockBits[$past(regionIdx)])
    else $error("region lock not set after programming");

  erase_abort_a: assert property (
    state == S_EXEC && latchMode == `FP_MODE_DATA && cmd == `FP_CMD_ERASE_ALL
    && !securityActive && lockBits != '0 |=> !ctlReq ##1 !ctlReq)
    else $error("erase-all ran with locked regions");

  secure_refuse_a: assert property (
    securityActive |-> !memReq && !(ctlReq && state != S_PIN_ERASE))
    else $error("command executed while secured");

  security_clear_a: assert property (
    $fell(securityActive) |-> $past(state == S_PIN_ERASE && ctlAck))
    else $error("security cleared without erase event");

  set_lock_mask_a: assert property (
    state == S_EXEC && latchMode == `FP_MODE_DATA && cmd == `FP_CMD_SET_LOCK
    && !securityActive |=> (lockBits & $past(latchData[LOCK_N-1:0]))
    == $past(latchData[LOCK_N-1:0]))
    else $error("lock mask not applied");
endmodule

`default_nettype wire

// ### tb/flash_backend_model.sv
// Back-end model: memory slave and flash controller facing the sequencer.
// Assumes each request is held by the sequencer until its one-cycle acknowledge.
`default_nettype none
module flash_backend_model
  import flash_prog_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic [15:0] memRdata,
  output logic memAck,
  input wire logic ctlReq,
  input wire flash_prog_pkg::ctl_op_e ctlOp,
  output logic ctlAck,
  output logic [6:0] ctlBufIdx,
  output int progCnt,
  output int eraseCnt,
  output int allCnt,
  output logic [31:0] lastAddr,
  output logic [15:0] lastData
);
  timeunit 1ns;
  timeprecision 1ps;
  int waitCnt;
  logic slow;

  // Latency alternates between prompt and slow so both paths are exercised.
  // Read data outside the acknowledge cycle toggles, so stale values never pass.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {memAck, ctlAck, slow, memRdata, ctlBufIdx} <= '0;
      {waitCnt, progCnt, eraseCnt, allCnt} <= '0;
      {lastAddr, lastData} <= '0;
    end
    else
    begin
      memAck <= 1'b0;
      ctlAck <= 1'b0;
      memRdata <= ~memRdata;
      ctlBufIdx <= ctlBufIdx + 7'h01;
      if ((memReq && !memAck) || (ctlReq && !ctlAck))
        waitCnt <= waitCnt + 1;
      if (memReq && !memAck && waitCnt >= (slow ? 3 : 0))
      begin
        memAck <= 1'b1;
        waitCnt <= 0;
        slow <= ~slow;
        memRdata <= memAddr[15:0] ^ memAddr[31:16];
        if (memWrite)
        begin
          lastAddr <= memAddr;
          lastData <= memWdata;
        end
      end
      if (ctlReq && !ctlAck && waitCnt >= (slow ? 3 : 0))
      begin
        ctlAck <= 1'b1;
        waitCnt <= 0;
        slow <= ~slow;
        eraseCnt <= eraseCnt + int'(ctlOp == OP_ERASE_PAGE);
        progCnt <= progCnt + int'(ctlOp == OP_PROGRAM_PAGE);
        allCnt <= allCnt + int'(ctlOp == OP_ERASE_ALL);
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/flash_prog_command_seq_tb.sv
// Self-checking bench for the programming command sequencer.
// Assumes the back-end model answers all memory and flash controller requests.
`default_nettype none
module flash_prog_command_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_prog_pkg::*;
  logic core_clk, resetn, strobeN, oeN, eraseEvent, ready, driveN, dataOe, ctlBufValid;
  logic memReq, memWrite, memAck, ctlReq, ctlAck, securityActive;
  logic [3:0] modeIn;
  logic [15:0] dataIn, dataOut, memWdata, memRdata, lastData, lockBits, v, ctlBufWord;
  logic [31:0] memAddr, lastAddr;
  logic [6:0] ctlBufIdx;
  logic [23:0] ctlPage;
  logic [1:0] optionBits;
  ctl_op_e ctlOp;
  int progCnt, eraseCnt, allCnt, failCount, nTests, cycles, p0, e0;

  flash_prog_command_seq DUT (.core_clk(core_clk), .resetn(resetn),
    .command_strobe_n(strobeN), .output_enable_n(oeN), .mode(modeIn), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe), .ready(ready), .data_drive_n(driveN),
    .eraseEvent(eraseEvent), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .ctlReq(ctlReq),
    .ctlOp(ctlOp), .ctlPage(ctlPage), .ctlAck(ctlAck), .ctlBufIdx(ctlBufIdx),
    .ctlBufWord(ctlBufWord), .ctlBufValid(ctlBufValid), .lockBits(lockBits),
    .optionBits(optionBits),
    .securityActive(securityActive));

  flash_backend_model partner (.core_clk(core_clk), .resetn(resetn), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memAck(memAck), .ctlReq(ctlReq), .ctlOp(ctlOp), .ctlAck(ctlAck),
    .ctlBufIdx(ctlBufIdx), .progCnt(progCnt), .eraseCnt(eraseCnt), .allCnt(allCnt),
    .lastAddr(lastAddr), .lastData(lastData));

  // ----------------------------------------------------------------------
  // Programmer handshakes
  // ----------------------------------------------------------------------
  // Outputs are sampled on the falling edge so they never race the drivers.
  task automatic waitReady;
    @(negedge core_clk);
    while (ready !== 1'b1) @(negedge core_clk);
  endtask

  task automatic startShake(input logic [3:0] m, input logic [15:0] d);
    waitReady;
    @(posedge core_clk);
    strobeN <= 1'b0;
    modeIn <= m;
    dataIn <= d;
    @(negedge core_clk);
    while (ready !== 1'b0) @(negedge core_clk);
  endtask

  task automatic wr(input logic [3:0] m, input logic [15:0] d);
    startShake(m, d);
    @(posedge core_clk);
    strobeN <= 1'b1;
    waitReady;
  endtask

  // The programmer lets go of the data lines; a toggled value stands for that.
  task automatic rd(output logic [15:0] q);
    startShake(4'h5, 16'h0000);
    @(posedge core_clk);
    oeN <= 1'b0;
    dataIn <= ~dataIn;
    @(negedge core_clk);
    while (driveN !== 1'b0) @(negedge core_clk);
    q = dataOut;
    chk(dataOe, 1'b1);
    @(posedge core_clk);
    oeN <= 1'b1;
    @(negedge core_clk);
    while (driveN !== 1'b1) @(negedge core_clk);
    chk(dataOe, 1'b0);
    @(posedge core_clk);
    strobeN <= 1'b1;
    waitReady;
  endtask

  task automatic cmd(input logic [15:0] c);
    wr(4'h0, c);
  endtask

  task automatic addr(input logic [31:0] a);
    for (int i = 0; i < 4; i++) wr(4'(i + 1), {8'h00, a[8*i+:8]});
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      failCount++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic tBits;
    cmd(16'h001e);
    rd(v);
    chk(v, 16'h0001);
    cmd(16'h0014);
    wr(4'h5, 16'h0005);
    cmd(16'h0024);
    wr(4'h5, 16'h0001);
    cmd(16'h0015);
    rd(v);
    chk(v, 16'h0004);
    cmd(16'h0034);
    wr(4'h5, 16'h0003);
    cmd(16'h0044);
    wr(4'h5, 16'h0001);
    cmd(16'h0025);
    wr(4'h6, 16'hffff);
    rd(v);
    chk(v, 16'h0002);
    cmd(16'h0077);
    wr(4'h5, 16'hffff);
    chk(lockBits, 16'h0004);
    p0 = allCnt;
    cmd(16'h0013);
    wr(4'h5, 16'h0000);
    chk(allCnt, p0);
    chk(optionBits, 2'b10);
    cmd(16'h0024);
    wr(4'h5, 16'hffff);
    cmd(16'h0013);
    wr(4'h5, 16'h0000);
    chk(allCnt, p0 + 1);
    chk(optionBits, 2'b00);
    $display("test bits done");
  endtask

  // Both read commands walk up from a loaded address, then jump on a reload.
  task automatic tRead;
    logic [15:0] codes [2] = '{16'h0011, 16'h0016};
    foreach (codes[i])
    begin
      cmd(codes[i]);
      addr(32'h1234_5678);
      rd(v);
      chk(v, 16'h444c);
      rd(v);
      chk(v, 16'h444e);
      addr(32'h00f0_0a00);
      rd(v);
      chk(v, 16'h0af0);
    end
    cmd(16'h0026);
    addr(32'h2000_0100);
    wr(4'h5, 16'h1111);
    wr(4'h5, 16'h2222);
    chk(lastAddr, 32'h2000_0102);
    chk(lastData, 16'h2222);
    $display("test read done");
  endtask

  // The last page of lock region k+1 is written; only erasing and locking codes act.
  task automatic tWrite;
    logic [15:0] codes [4] = '{16'h0012, 16'h0022, 16'h0032, 16'h0042};
    foreach (codes[k])
    begin
      p0 = progCnt;
      e0 = eraseCnt;
      cmd(codes[k]);
      addr(32'h4000 * (k + 1) + 32'h3f00);
      wr(4'h5, 16'hc000);
      wr(4'h5, 16'hc001);
      chk(progCnt, p0);
      // The word read out lags the index by one cycle, so index 2 shows word 1.
      while (ctlBufIdx != 7'h02) @(negedge core_clk);
      chk({ctlBufValid, ctlBufWord}, 17'h1c001);
      cmd(16'h001e);
      chk(ctlPage, 32'h40 * (k + 1) + 32'h3f);
      chk(progCnt, p0 + 1);
      chk(eraseCnt, e0 + int'(k > 1));
      chk(lockBits[k+1], k == 1 || k == 3);
    end
    p0 = progCnt;
    cmd(16'h0012);
    addr(32'h0000_0000);
    wr(4'h5, 16'h0101);
    addr(32'h0000_0100);
    wr(4'h5, 16'h0202);
    chk(progCnt, p0 + 1);
    cmd(16'h0015);
    chk(progCnt, p0 + 2);
    $display("test write done");
  endtask

  task automatic tSecurity;
    p0 = allCnt;
    cmd(16'h0054);
    wr(4'h5, 16'h0000);
    chk(securityActive, 1'b1);
    cmd(16'h0014);
    wr(4'h5, 16'h0001);
    chk(lockBits, 16'h0014);
    @(posedge core_clk);
    eraseEvent <= 1'b1;
    @(posedge core_clk);
    eraseEvent <= 1'b0;
    @(negedge core_clk);
    while (allCnt == p0) @(negedge core_clk);
    waitReady;
    chk(allCnt, p0 + 1);
    chk(securityActive, 1'b0);
    chk(lockBits, 16'h0000);
    cmd(16'h0035);
    rd(v);
    chk(v, 16'h0000);
    $display("test security done");
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // A hang anywhere ends the run well past the thousand or so cycles needed.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failCount++;
      wrapUp;
    end
  end

  initial
  begin
    {resetn, modeIn, dataIn, eraseEvent} = '0;
    {strobeN, oeN} = 2'b11;
    {failCount, nTests, cycles} = '0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    tBits;
    tRead;
    tWrite;
    tSecurity;
    wrapUp;
  end
endmodule
`default_nettype wire
